/* pwm7_params.svh */
// register map, field codes and reset values for the 7-bit pwm channel
`ifndef PWM7_PARAMS_SVH
`define PWM7_PARAMS_SVH
`define PWM7_ADDR_W 8
`define PWM7_OFF_MODE 8'h00
`define PWM7_OFF_PAIR 8'h04
`define PWM7_OFF_DUTY 8'h08
`define PWM7_OFF_STAT 8'h0c
`define PWM7_OFF_SYS 8'h10
`define PWM7_MODE_RST 8'h00
`define PWM7_PAIR_RST 8'h00
`define PWM7_SYS_RST 8'h00
`define PWM7_DUTY_RST 8'hff
`define PWM7_MODE_PWM 2'h2
`define PWM7_CNT_ZERO 7'h00
`define PWM7_CNT_LAST 7'h7f
`define PWM7_CNT_ONE 7'h01
`define PWM7_TCK_D11 3'h0
`define PWM7_TCK_D10 3'h1
`define PWM7_TCK_D8 3'h2
`define PWM7_TCK_D6 3'h3
`define PWM7_TCK_D4 3'h4
`define PWM7_TCK_D2 3'h5
`define PWM7_TCK_D1 3'h6
`define PWM7_TCK_D0 3'h7
`define PWM7_PRE_W 11
`define PWM7_PRE_ONE 11'h001
`define PWM7_FS_W 4
`define PWM7_FS_ONE 4'h1
`endif

/* pwm7_pkg.sv */
// types shared by the 7-bit pwm channel
`default_nettype none
package pwm7_pkg;
	typedef struct packed {
		logic [2:0] clock_select_field;
		logic [1:0] mode_field;
		logic external_input_select;
		logic double_buffer_enable;
		logic initial_level_bit;
	} pwm7_mode_s;
	typedef struct packed {
		logic [4:0] pad;
		logic cascade_bit;
		logic output_and_bit;
		logic channel_run_bit;
	} pwm7_pair_s;
	typedef struct packed {
		logic [5:0] pad;
		logic slow_mode;
		logic low_freq_divider_select;
	} pwm7_sys_s;
	typedef struct packed {
		logic [6:0] duty;
		logic add_pulse_bit;
	} pwm7_duty_s;
	typedef enum logic [1:0] {
		PWM7_ST_IDLE = 2'b01,
		PWM7_ST_RUN = 2'b10
	} pwm7_state_e;
endpackage : pwm7_pkg
`default_nettype wire

/* pwm7_timer.sv */
// 7-bit pwm channel with add-pulse stretch, double buffer and apb slave
//
// Behaviour
// - idle pin level follows the initial-level bit: 0 low, 1 high
// - stopped timer with pin routed drives the initial-level bit
// - output-and bit set: pin carries own output and sibling output
// - run bit set: counter advances once per selected source tick
// - low 7 count bits equal duty field: output leaves initial level
// - add-pulse set: every second duty match delayed one source count
// - add-pulse clear: no duty phase is ever stretched
// - count 128 overflows to zero, output returns to initial level
// - interrupt pulse only on even-numbered overflows
// - clearing run stops, zeroes counter, restores initial level
// - double-buffer bit 0 disables, 1 enables duty buffering
// - buffered running write waits for even overflow to load
// - buffered duty read returns last written value
// - stopped duty write updates active value at once, and the buffer too when buffering is enabled
// - unbuffered running write acts at once; lower value waits wrap
// - unbuffered write equal to count matches right after write
// - unbuffered write during stretch may give an off-grid edge
// - clock select picks gear or low-freq divider; slow mode limited
// - duty register: 7-bit duty high, add-pulse bit 0, resets ones
// - one output period is 128 source counts
`include "pwm7_params.svh"
`default_nettype none
module pwm7_timer
	import pwm7_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic low_freq_clock,
	input wire logic sibling_out,
	input wire logic port_function_sel,
	output logic pulse_out_pin,
	output logic pulse_out_oe,
	output logic channel_out,
	output logic channel_irq
);
	// registers
	pwm7_mode_s channel_mode_reg;
	pwm7_pair_s pair_control_reg;
	pwm7_sys_s system_control_reg;
	pwm7_duty_s duty_reg;
	pwm7_duty_s duty_buf;
	pwm7_state_e state;
	logic [6:0] count;
	logic level;
	logic even_phase;
	logic [`PWM7_PRE_W-1:0] prescale;
	logic [`PWM7_FS_W-1:0] fs_count;
	logic lf_meta;
	logic lf_sync;
	logic lf_prev;

	// apb decode
	wire [`PWM7_ADDR_W-1:0] reg_addr = paddr[`PWM7_ADDR_W-1:0];
	wire hi_zero = (paddr[31:`PWM7_ADDR_W] == 24'h000000);
	wire hit_mode = hi_zero && (reg_addr == `PWM7_OFF_MODE);
	wire hit_pair = hi_zero && (reg_addr == `PWM7_OFF_PAIR);
	wire hit_duty = hi_zero && (reg_addr == `PWM7_OFF_DUTY);
	wire hit_stat = hi_zero && (reg_addr == `PWM7_OFF_STAT);
	wire hit_sys = hi_zero && (reg_addr == `PWM7_OFF_SYS);
	wire hit_any = hit_mode | hit_pair | hit_duty | hit_stat | hit_sys;
	wire setup_ph = psel & ~penable;
	wire access_ok = psel & penable & pready & ~pslverr;
	wire wr_en = access_ok & pwrite;
	wire running = (state == PWM7_ST_RUN);

	// write strobes per register
	wire wr_mode = wr_en & hit_mode & ~running;
	wire wr_pair = wr_en & hit_pair;
	wire wr_duty = wr_en & hit_duty;
	wire wr_sys = wr_en & hit_sys;

	// run control, next state
	wire run_req = wr_pair ? pwdata[0] : pair_control_reg.channel_run_bit;
	wire start = run_req & ~running;
	wire stop = ~run_req & running;

	// read mux; buffered channel reads back the buffer
	wire [7:0] duty_rd = channel_mode_reg.double_buffer_enable ?
		duty_buf : duty_reg;
	wire [31:0] stat_rd = {21'h00000, even_phase, running, level,
		1'b0, count};
	wire [31:0] rd_mux =
		hit_mode ? {24'h000000, channel_mode_reg} :
		hit_pair ? {24'h000000, pair_control_reg} :
		hit_duty ? {24'h000000, duty_rd} :
		hit_sys ? {24'h000000, system_control_reg} :
		hit_stat ? stat_rd : 32'h00000000;

	// gear clock dividers from the free prescaler
	wire g_d1 = prescale[0];
	wire g_d2 = &prescale[1:0];
	wire g_d4 = &prescale[3:0];
	wire g_d6 = &prescale[5:0];
	wire g_d8 = &prescale[7:0];
	wire g_d10 = &prescale[9:0];
	wire g_d11 = &prescale[10:0];

	// low-freq edge; only the second, third and fourth stages are looked at
	wire lf_edge = lf_sync & ~lf_prev;
	wire f_d2 = lf_edge & (&fs_count[1:0]);
	wire f_d3 = lf_edge & (&fs_count[2:0]);
	wire f_d4 = lf_edge & (&fs_count[3:0]);

	// source clock select
	wire [2:0] tck = channel_mode_reg.clock_select_field;
	wire dv = system_control_reg.low_freq_divider_select;
	wire slow = system_control_reg.slow_mode;
	wire tick_normal =
		(tck == `PWM7_TCK_D11) ? (dv ? f_d4 : g_d11) :
		(tck == `PWM7_TCK_D10) ? (dv ? f_d3 : g_d10) :
		(tck == `PWM7_TCK_D8) ? g_d8 :
		(tck == `PWM7_TCK_D6) ? g_d6 :
		(tck == `PWM7_TCK_D4) ? g_d4 :
		(tck == `PWM7_TCK_D2) ? g_d2 :
		(tck == `PWM7_TCK_D1) ? g_d1 : 1'b1;
	// slow mode: other codes give no clock at all
	wire tick_slow =
		(tck == `PWM7_TCK_D11) ? f_d4 :
		(tck == `PWM7_TCK_D10) ? f_d3 :
		(tck == `PWM7_TCK_D0) ? f_d2 : 1'b0;
	wire src_tick = slow ? tick_slow : tick_normal;

	// counter and match
	wire cnt_wrap = running & src_tick &
		(count == `PWM7_CNT_LAST);
	wire stretch = duty_reg.add_pulse_bit & even_phase;
	// compare is live every clock, so an equal write matches at once
	wire [7:0] cmp_val = {1'b0, duty_reg.duty} +
		{7'h00, stretch};
	// toggle on the edge that brings count to the compare value, so
	// every phase is a whole number of source counts
	wire hit_next = running & src_tick & ~cnt_wrap &
		({1'b0, count + `PWM7_CNT_ONE} == cmp_val);
	// live compare only acts for a write equal to the running count or for a cmp_val of zero
	wire match = hit_next |
		(running & ({1'b0, count} == cmp_val));
	wire irq_evt = cnt_wrap & even_phase;
	wire tff = channel_mode_reg.initial_level_bit;

	// next values; stop clears at once, not a cycle later
	wire halt = ~running | stop;
	wire [6:0] next_count = halt ? `PWM7_CNT_ZERO :
		cnt_wrap ? `PWM7_CNT_ZERO :
		src_tick ? count + `PWM7_CNT_ONE : count;
	wire next_level = halt ? tff :
		cnt_wrap ? tff :
		match ? ~tff : level;
	wire next_phase = (start | stop | ~running) ? 1'b0 :
		cnt_wrap ? ~even_phase : even_phase;
	wire own_pin = pair_control_reg.output_and_bit ?
		(level & sibling_out) : level;

	// duty write routing
	wire dbe = channel_mode_reg.double_buffer_enable;
	wire duty_act_wr = wr_duty & (~running | ~dbe);
	wire duty_buf_wr = wr_duty & dbe;
	wire duty_load = irq_evt & dbe & ~duty_act_wr;

	// apb handshake; no wait states, data held in flops
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup_ph;
			pslverr <= setup_ph & ~hit_any;
			if (setup_ph) begin
				prdata <= rd_mux;
			end
		end
	end

	// software registers
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			channel_mode_reg <= `PWM7_MODE_RST;
			pair_control_reg <= `PWM7_PAIR_RST;
			system_control_reg <= `PWM7_SYS_RST;
		end else begin
			if (wr_mode) begin
				channel_mode_reg <= pwdata[7:0];
			end
			if (wr_pair) begin
				pair_control_reg <= {5'h00, pwdata[2:0]};
			end
			if (wr_sys) begin
				system_control_reg <= {6'h00, pwdata[1:0]};
			end
		end
	end

	// duty and its buffer, both reset to all ones
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			duty_reg <= `PWM7_DUTY_RST;
			duty_buf <= `PWM7_DUTY_RST;
		end else begin
			if (duty_act_wr) begin
				duty_reg <= pwdata[7:0];
			end else if (duty_load) begin
				duty_reg <= duty_buf;
			end
			if (duty_buf_wr) begin
				duty_buf <= pwdata[7:0];
			end
		end
	end

	// run state
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state <= PWM7_ST_IDLE;
		end else begin
			case (state)
				PWM7_ST_IDLE: begin
					if (start) begin
						state <= PWM7_ST_RUN;
					end
				end
				PWM7_ST_RUN: begin
					if (stop) begin
						state <= PWM7_ST_IDLE;
					end
				end
				default: begin
					state <= PWM7_ST_IDLE;
				end
			endcase
		end
	end

	// counter, level and phase
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			count <= `PWM7_CNT_ZERO;
			level <= 1'b0;
			even_phase <= 1'b0;
		end else begin
			count <= next_count;
			level <= next_level;
			even_phase <= next_phase;
		end
	end

	// prescalers and low-freq synchroniser
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			prescale <= '0;
			fs_count <= '0;
			lf_meta <= 1'b0;
			lf_sync <= 1'b0;
			lf_prev <= 1'b0;
		end else begin
			prescale <= prescale + `PWM7_PRE_ONE;
			lf_meta <= low_freq_clock;
			lf_sync <= lf_meta;
			lf_prev <= lf_sync;
			if (lf_edge) begin
				fs_count <= fs_count + `PWM7_FS_ONE;
			end
		end
	end

	// pin stage; all outputs registered, so pin and channel_out are one clock behind level
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			pulse_out_pin <= 1'b0;
			pulse_out_oe <= 1'b0;
			channel_out <= 1'b0;
			channel_irq <= 1'b0;
		end else begin
			pulse_out_pin <= own_pin;
			pulse_out_oe <= port_function_sel;
			channel_out <= level;
			channel_irq <= irq_evt;
		end
	end

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	sequence s_wrap;
		running && src_tick && count == `PWM7_CNT_LAST;
	endsequence
	sequence s_idle_lvl;
		!running;
	endsequence
	sequence s_step_hit;
		hit_next && !stop;
	endsequence

	a_stop_clears: assert property (
		stop |=> count == `PWM7_CNT_ZERO && level == $past(tff))
		else $error("stop did not clear counter and level");
	a_idle_level: assert property (
		s_idle_lvl |=> level == $past(tff))
		else $error("idle level differs from initial level");
	a_pin_idle: assert property (
		!running && !pair_control_reg.output_and_bit && $stable(tff)
		|=> pulse_out_pin == $past(tff))
		else $error("stopped pin not at initial level");
	a_and_pin: assert property (
		pair_control_reg.output_and_bit |=>
		pulse_out_pin == ($past(level) & $past(sibling_out)))
		else $error("and output wrong");
	a_count_step: assert property (
		running && src_tick && count != `PWM7_CNT_LAST && !stop
		|=> count == $past(count) + `PWM7_CNT_ONE)
		else $error("counter did not advance on tick");
	a_count_hold: assert property (
		running && !src_tick && !stop |=> $stable(count))
		else $error("counter moved without tick");
	a_match_level: assert property (
		match && !cnt_wrap && !stop |=> level == !$past(tff))
		else $error("match did not leave initial level");
	a_wrap_level: assert property (
		s_wrap ##0 !stop |=> count == `PWM7_CNT_ZERO && level == tff)
		else $error("overflow did not restore level");
	a_irq_even: assert property (
		s_wrap ##0 !even_phase |=> !channel_irq)
		else $error("interrupt on odd overflow");
	a_irq_pulse: assert property (
		s_wrap ##0 even_phase |=> channel_irq)
		else $error("even overflow gave no interrupt");
	a_no_stretch: assert property (
		!duty_reg.add_pulse_bit |-> cmp_val == {1'b0, duty_reg.duty})
		else $error("stretch without add-pulse");
	a_buf_hold: assert property (
		running && dbe && wr_duty && !irq_evt |=> $stable(duty_reg))
		else $error("buffered write reached active duty");
	a_buf_load: assert property (
		irq_evt && dbe && !wr_duty |=> duty_reg == $past(duty_buf))
		else $error("buffer not loaded at even overflow");
	a_stop_write: assert property (
		!running && wr_duty |=> duty_reg == $past(pwdata[7:0]))
		else $error("stopped duty write not immediate");
	a_phase_start: assert property (
		start |=> !even_phase)
		else $error("phase not cleared at start");
	a_mode_lock: assert property (
		running |=> $stable(channel_mode_reg))
		else $error("mode changed while running");
	a_step_match: assert property (
		s_step_hit |=> level == !$past(tff))
		else $error("match step did not toggle level");
	a_slow_gate: assert property (
		slow && tck != `PWM7_TCK_D11 && tck != `PWM7_TCK_D10 &&
		tck != `PWM7_TCK_D0 |-> !src_tick)
		else $error("slow mode tick on unsupported code");
	a_buf_read: assert property (
		setup_ph && hit_duty && dbe |=> prdata[7:0] == $past(duty_buf))
		else $error("buffered duty read not from buffer");
	a_unbuf_write: assert property (
		running && !dbe && wr_duty |=> duty_reg == $past(pwdata[7:0]))
		else $error("unbuffered running write not immediate");
	a_phase_stop: assert property (
		stop |=> !even_phase)
		else $error("phase not cleared at stop");
	a_wrap_phase: assert property (
		s_wrap ##0 !stop |=> even_phase != $past(even_phase))
		else $error("overflow did not flip phase");
	a_err_resp: assert property (
		setup_ph && !hit_any |=> pslverr && prdata == 32'h00000000)
		else $error("unmapped access without error response");
endmodule : pwm7_timer
`default_nettype wire

/* pwm7_timer_tb.sv */
// self-checking testbench for the 7-bit pwm channel
`include "pwm7_params.svh"
`default_nettype none
module pwm7_timer_tb
	import pwm7_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic low_freq_clock = 1'b0;
	logic [2:0] lf_div = 3'h0;
	logic sibling_out = 1'b0;
	logic port_function_sel = 1'b0;
	logic pulse_out_pin;
	logic pulse_out_oe;
	logic channel_out;
	logic channel_irq;
	int n_mismatch = 0;
	int compares = 0;
	int n_irq = 0;
	int len = 0;
	int q[$];
	bit mon = 1'b0;
	logic prev = 1'b0;
	logic [31:0] rd;
	logic err;
	logic [31:0] offs [4] = '{32'h00, 32'h04, 32'h08, 32'h10};
	logic [31:0] rstv [4] = '{32'h00, 32'h00, 32'hff, 32'h00};

	pwm7_timer dut (.clock(clock), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.low_freq_clock(low_freq_clock), .sibling_out(sibling_out),
		.port_function_sel(port_function_sel), .pulse_out_pin(pulse_out_pin),
		.pulse_out_oe(pulse_out_oe), .channel_out(channel_out),
		.channel_irq(channel_irq));

	always #2 clock = ~clock;

	// free-running low-freq pin, one rising edge every eight clocks
	always @(posedge clock) begin
		lf_div <= lf_div + 3'h1;
		low_freq_clock <= lf_div[2];
	end

	// run lengths of the channel level, in clock edges between changes
	always @(posedge clock) begin
		if (mon && channel_out !== prev) begin
			q.push_back(len);
			len = 1;
		end else begin
			len++;
		end
		prev = channel_out;
		if (mon && channel_irq === 1'b1) begin
			n_irq++;
		end
	end

	task test_done;
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done

	task check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// entered right after a rising edge; holds all until pready is seen
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (i >= 50) begin
			n_mismatch++;
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb

	task automatic run_case(input logic [2:0] tck, input logic tff,
		input logic ad,
		input logic dbe, input int div);
		pwm7_mode_s m;
		logic [6:0] d1;
		logic [6:0] d2;
		int e[$];
		int dk;
		int st;
		d1 = 7'($urandom_range(20, 110));
		d2 = 7'($urandom_range(20, 110));
		m = '{tck, `PWM7_MODE_PWM, 1'b0, dbe, tff};
		apb(1'b1, `PWM7_OFF_MODE, {24'h0, m});
		apb(1'b1, `PWM7_OFF_DUTY, {24'h0, d1, ad});
		q.delete();
		n_irq = 0;
		mon = 1'b1;
		apb(1'b1, `PWM7_OFF_PAIR, 32'h1);
		apb(1'b1, `PWM7_OFF_DUTY, {24'h0, d2, ad});
		apb(1'b1, `PWM7_OFF_MODE, {24'h0, m ^ 8'h01});
		apb(1'b0, `PWM7_OFF_MODE, 32'h0);
		check(rd, {24'h0, m});
		apb(1'b0, `PWM7_OFF_DUTY, 32'h0);
		check(rd, {24'h0, d2, ad});
		repeat (515 * div) @(posedge clock);
		apb(1'b1, `PWM7_OFF_PAIR, 32'h0);
		repeat (3) @(posedge clock);
		mon = 1'b0;
		check(n_irq, 2);
		// buffered writes wait for the second overflow
		for (int k = 1; k <= 4; k++) begin
			dk = (k >= (dbe ? 3 : 1)) ? int'(d2) : int'(d1);
			st = (ad && k % 2 == 0) ? 1 : 0;
			if (k > 1) begin
				e.push_back((dk + st) * div);
			end
			e.push_back((128 - dk - st) * div);
		end
		if (q.size() > 0) begin
			void'(q.pop_front());
		end
		check(q.size(), 7);
		foreach (e[i]) begin
			check(q[i], e[i]);
		end
		apb(1'b0, `PWM7_OFF_STAT, 32'h0);
		check(rd & 32'h37f, {23'h0, tff, 8'h0});
		check(pulse_out_pin, tff);
		$display("test run tck=%0d dbe=%0d ad=%0d done", tck, dbe, ad);
	endtask : run_case

	initial begin
		void'($urandom(32'h7cdc));
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		port_function_sel <= 1'b1;
		@(posedge clock);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, offs[i], 32'h0);
			check(rd, rstv[i]);
		end
		apb(1'b0, 32'h14, 32'h0);
		check(err, 1'b1);
		apb(1'b0, 32'h100, 32'h0);
		check(err, 1'b1);
		check(rd, 32'h0);
		$display("test reset values done");
		apb(1'b1, `PWM7_OFF_MODE, 32'h11);
		repeat (3) @(posedge clock);
		check(pulse_out_pin, 1'b1);
		check(pulse_out_oe, 1'b1);
		apb(1'b1, `PWM7_OFF_PAIR, 32'h2);
		for (int i = 0; i < 6; i++) begin
			sibling_out <= 1'($urandom_range(0, 1));
			repeat (3) @(posedge clock);
			check(pulse_out_pin, sibling_out);
		end
		apb(1'b1, `PWM7_OFF_PAIR, 32'h0);
		sibling_out <= 1'b1;
		port_function_sel <= 1'b0;
		apb(1'b1, `PWM7_OFF_MODE, 32'h10);
		repeat (3) @(posedge clock);
		check(pulse_out_oe, 1'b0);
		port_function_sel <= 1'b1;
		repeat (3) @(posedge clock);
		check(pulse_out_pin, 1'b0);
		$display("test idle pin done");
		// divided sources stretch every phase by the divider
		run_case(3'h7, 1'b0, 1'b1, 1'b0, 1);
		run_case(3'h7, 1'b1, 1'b1, 1'b1, 1);
		run_case(3'h6, 1'b0, 1'b0, 1'b0, 2);
		run_case(3'h5, 1'b1, 1'b0, 1'b1, 4);
		run_case(3'h4, 1'b0, 1'b1, 1'b1, 16);
		// slow mode: code 7 runs at a quarter of the low-freq edges
		apb(1'b1, `PWM7_OFF_SYS, 32'h2);
		run_case(3'h7, 1'b1, 1'b1, 1'b0, 32);
		// slow mode refuses the gear codes, so the counter stays frozen
		apb(1'b1, `PWM7_OFF_MODE, {24'h0, 3'h2, 2'h2, 3'h0});
		apb(1'b1, `PWM7_OFF_PAIR, 32'h1);
		repeat (200) @(posedge clock);
		apb(1'b0, `PWM7_OFF_STAT, 32'h0);
		check(rd & 32'h27f, 32'h200);
		apb(1'b1, `PWM7_OFF_PAIR, 32'h0);
		$display("test slow freeze done");
		// low-freq divider select in normal mode
		apb(1'b1, `PWM7_OFF_SYS, 32'h1);
		run_case(3'h1, 1'b0, 1'b1, 1'b0, 64);
		apb(1'b1, `PWM7_OFF_SYS, 32'h0);
		test_done();
	end
endmodule : pwm7_timer_tb
`default_nettype wire
